// *** inc/adcsc_pkg.sv ***
// Overview of operation
// - Power-on reset or standby clears the control/status register; manual reset keeps it.
// - Power-on reset or standby clears the control register; manual reset keeps it.
// - End flag accepts only a written zero; writing one does nothing.
// - Writing zero clears the end flag only after it was read set.
// - Transfer controller acknowledge of the end interrupt clears the end flag.
// - Single mode sets end flag after all channels, or after buffer sequence.
// - Scan mode sets end flag after one full round over all channels.
// - Interrupt enable gates the end interrupt request.
// - Start bit is set by software, selected timer trigger, or external pin.
// - Single mode holds start bit during conversion, clears it when done.
// - Scan mode converts continuously until software writes zero to start.
// - Start bit zero halts conversion; it resets to zero.
// - Time select: zero gives 40 states at clock/2, one gives 80 at clock/4.
// - Select mode converts channel n; group mode converts 0 through n.
// - Control register bit 7 reads zero; software writes zero.
// - Start mode bit: zero low power, one high speed start.
// - Trigger select: 00 software, 01 timer, 11 external pin, 10 reserved.
// - Repeat bit: zero single mode, one scan mode.
// - Dual sample bit: zero normal, one samples two channels together.
// - Buffer select chains results A-B, A-C/B-D, or A-B-C-D.
// - Result registers read as 16-bit words or single bytes.
// - Byte read of a result returns result bits 9 through 2.
// - Result holds 10 bits in 9..0; bits 15..10 read zero.
// - Scan with interrupt enabled halts on end flag, resumes when cleared.
package adcsc_pkg;
    localparam logic [4:0] ADDR_CSR    = 5'h10;
    localparam logic [4:0] ADDR_CR     = 5'h11;
    localparam logic [4:0] ADDR_RES0   = 5'h00;
    localparam logic [4:0] ADDR_RESB0  = 5'h08;
    localparam logic [7:0] CSR_RESET   = 8'h00;
    localparam logic [7:0] CR_RESET    = 8'h00;
    localparam int BIT_FLAG   = 7;
    localparam int BIT_IE     = 6;
    localparam int BIT_START  = 5;
    localparam int BIT_CKS    = 4;
    localparam int BIT_GRP    = 3;
    localparam int BIT_PWR    = 6;
    localparam int BIT_SCAN   = 3;
    localparam int BIT_DUAL_SAMPLE_ENABLE   = 2;
    localparam logic [1:0] TRG_SW   = 2'h0;
    localparam logic [1:0] TRG_TMR  = 2'h1;
    localparam logic [1:0] TRG_EXT  = 2'h3;
    localparam logic [1:0] BUF_NONE = 2'h0;
    localparam logic [1:0] BUF_AB   = 2'h1;
    localparam logic [1:0] BUF_ACBD = 2'h2;
    localparam logic [1:0] BUF_ABCD = 2'h3;
    localparam int STATES_FAST = 40;
    localparam int STATES_SLOW = 80;
    localparam int DIV_FAST    = 2;
    localparam int DIV_SLOW    = 4;
    localparam logic [6:0] CONV_FAST_CYC = 7'(STATES_FAST * DIV_FAST / DIV_FAST * 2 / 2);
    localparam logic [6:0] CONV_SLOW_CYC = 7'(STATES_SLOW);
    localparam logic [15:0] RES_MASK = 16'h03ff;
    typedef enum logic [1:0] {
        ADCSC_IDLE = 2'b00,
        ADCSC_CONV = 2'b01,
        ADCSC_HOLD = 2'b10
    } adcsc_state_t;
endpackage

// *** core/adcsc_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
// Counts conversion states of one channel; one state per system clock
module adcsc_timer
    import adcsc_pkg::*;
(
    input  wire logic sys_clk_in,
    input  wire logic arst_n_in,
    input  wire logic run_in,
    input  wire logic slow_in,
    output logic      done_out
);
    logic [6:0] cnt_q;
    logic [6:0] cnt_d;
    logic [6:0] limit;

    // Conversion length in states from the time select
    always_comb begin
        limit = slow_in ? CONV_SLOW_CYC : CONV_FAST_CYC;
        cnt_d = cnt_q;
        if (!run_in) begin
            cnt_d = 7'h00;
        end else if (cnt_q == limit - 7'h01) begin
            cnt_d = 7'h00;
        end else begin
            cnt_d = cnt_q + 7'h01;
        end
    end

    assign done_out = run_in && (cnt_q == limit - 7'h01);

    // Counter register
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cnt_q <= 7'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule
`default_nettype wire

// *** core/adcsc_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// Conversion sequencer control with register port and result file
module adcsc_top
    import adcsc_pkg::*;
(
    input  wire logic        sys_clk_in,
    input  wire logic        arst_n_in,
    input  wire logic        standby_in,
    input  wire logic        manual_rst_in,
    input  wire logic [4:0]  addr_in,
    input  wire logic [15:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic [15:0]      rdata_out,
    input  wire logic        timer_trig_in,
    input  wire logic        ext_trigger_pin_in,
    input  wire logic        xfer_ack_in,
    input  wire logic [9:0]  sample_in,
    output logic [2:0]       mux_chan_out,
    output logic             sampling_out,
    output logic             high_speed_out,
    output logic             dual_sample_out,
    output logic             conv_end_irq_out
);
    logic [7:0]         csr_q;
    logic [7:0]         csr_d;
    logic [7:0]         cr_q;
    logic [7:0]         cr_d;
    logic               armed_q;
    logic               armed_d;
    adcsc_state_t       state_q;
    adcsc_state_t       state_d;
    logic [2:0]         chan_q;
    logic [2:0]         chan_d;
    logic [1:0]         bufcnt_q;
    logic [1:0]         bufcnt_d;
    logic [9:0]         res_q [0:7];
    logic [9:0]         res_d [0:7];
    logic [15:0]        rdata_q;
    logic [15:0]        rdata_d;
    logic               ext_q;
    logic               conv_done;
    logic               round_end;
    logic               set_flag;
    logic               trig;
    logic               scan;
    logic [2:0]         last_chan;
    logic               wr_csr;
    logic               wr_cr;
    logic               rd_csr;

    // First channel of a round: zero in group mode, the code itself in select mode
    function automatic logic [2:0] first_chan(input logic group_select, input logic [2:0] code);
        first_chan = group_select ? 3'h0 : code;
    endfunction

    // Rounds a buffer sequence completes before the round that sets the flag
    function automatic logic [1:0] buf_rounds(input logic [1:0] sel);
        case (sel)
            BUF_ABCD: buf_rounds = 2'h3;
            BUF_ACBD: buf_rounds = 2'h1;
            BUF_AB:   buf_rounds = 2'h1;
            default:  buf_rounds = 2'h0;
        endcase
    endfunction

    // One register of the port is hit by this strobe
    function automatic logic reg_hit(input logic strobe, input logic [4:0] addr,
                                     input logic [4:0] target);
        reg_hit = strobe && (addr == target);
    endfunction

    adcsc_timer u_timer (
        .sys_clk_in (sys_clk_in),
        .arst_n_in  (arst_n_in),
        .run_in     (state_q == ADCSC_CONV),
        .slow_in    (csr_q[BIT_CKS]),
        .done_out   (conv_done)
    );

    assign scan      = cr_q[BIT_SCAN];
    assign last_chan = csr_q[2:0];
    // Strobe decode shared by the flag logic and the register writes
    assign wr_csr    = reg_hit(wr_in, addr_in, ADDR_CSR);
    assign wr_cr     = reg_hit(wr_in, addr_in, ADDR_CR);
    assign rd_csr    = reg_hit(rd_in, addr_in, ADDR_CSR);
    // Start source by trigger select; reserved code starts nothing
    assign trig = (cr_q[5:4] == TRG_TMR && timer_trig_in)
               || (cr_q[5:4] == TRG_EXT && ext_trigger_pin_in && !ext_q);
    // Group mode ends the round on the coded channel
    assign round_end = conv_done && (chan_q == last_chan);
    // Flag sets after a full round, or after the buffer sequence
    assign set_flag = round_end
        && (scan || cr_q[1:0] == BUF_NONE || bufcnt_q == buf_rounds(cr_q[1:0]));

    // Register file, flag and start control
    always_comb begin
        csr_d   = csr_q;
        cr_d    = cr_q;
        armed_d = armed_q;
        if (wr_csr) begin
            // Mode bits follow software; halting is the caller's duty
            csr_d[6:0] = wdata_in[6:0];
            // Zero clears only after a read saw it set; one is ignored
            if (!wdata_in[BIT_FLAG] && armed_q) begin
                csr_d[BIT_FLAG] = 1'b0;
                armed_d         = 1'b0;
            end
        end
        if (wr_cr) begin
            cr_d = {1'b0, wdata_in[6:0]};
        end
        if (rd_csr && csr_q[BIT_FLAG]) begin
            armed_d = 1'b1;
        end
        if (xfer_ack_in) begin
            csr_d[BIT_FLAG] = 1'b0;
            armed_d         = 1'b0;
        end
        if (trig) begin
            csr_d[BIT_START] = 1'b1;
        end
        // Single mode drops the start bit at every round end, buffered or not, unless a trigger arrives in that cycle
        if (round_end && !scan && !trig) begin
            csr_d[BIT_START] = 1'b0;
        end
        // Set wins over a write or acknowledge clear in the same cycle
        if (set_flag) begin
            csr_d[BIT_FLAG] = 1'b1;
        end
        if (standby_in) begin
            csr_d   = CSR_RESET;
            cr_d    = CR_RESET;
            armed_d = 1'b0;
        end else if (manual_rst_in) begin
            csr_d   = csr_q;
            cr_d    = cr_q;
            armed_d = armed_q;
        end
    end

    // Sequencer: walks channels while the start bit is high
    always_comb begin
        state_d  = state_q;
        chan_d   = chan_q;
        bufcnt_d = bufcnt_q;
        case (state_q)
            ADCSC_IDLE: begin
                chan_d = first_chan(csr_q[BIT_GRP], last_chan);
                if (csr_q[BIT_START]) begin
                    state_d = ADCSC_CONV;
                end
            end
            ADCSC_CONV: begin
                if (conv_done) begin
                    chan_d = (chan_q == last_chan) ? first_chan(csr_q[BIT_GRP], last_chan)
                                                   : chan_q + 3'h1;
                end
                if (round_end) begin
                    bufcnt_d = set_flag ? 2'h0 : bufcnt_q + 2'h1;
                    if (set_flag && scan && csr_q[BIT_IE]) begin
                        state_d = ADCSC_HOLD;
                    end else if (set_flag && !scan) begin
                        state_d = ADCSC_IDLE;
                    end else if (!scan) begin
                        state_d = ADCSC_IDLE; // Buffer step; waits for next start
                    end
                end
            end
            ADCSC_HOLD: begin
                if (!csr_q[BIT_FLAG]) begin
                    state_d = ADCSC_CONV;
                end
            end
            default: state_d = ADCSC_IDLE;
        endcase
        // Start bit low halts at once; standby has its own check below
        if (!csr_q[BIT_START] && state_q != ADCSC_IDLE) begin
            state_d = ADCSC_IDLE;
        end
        // Standby stops at once rather than a cycle later through the start bit
        if (standby_in) begin
            state_d  = ADCSC_IDLE;
            bufcnt_d = 2'h0;
        end
    end

    // Result store with buffer chaining on each finished channel
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            res_d[i] = res_q[i];
        end
        if (conv_done && state_q == ADCSC_CONV) begin
            case (cr_q[1:0])
                BUF_AB: begin
                    if (chan_q == 3'h0) begin
                        res_d[1] = res_q[0];
                        res_d[0] = sample_in;
                    end else if (chan_q != 3'h1) begin
                        res_d[chan_q] = sample_in;
                    end
                end
                BUF_ACBD: begin
                    if (chan_q == 3'h0 || chan_q == 3'h1) begin
                        res_d[{2'b01, chan_q[0]}] = res_q[{2'b00, chan_q[0]}];
                        res_d[{2'b00, chan_q[0]}] = sample_in;
                    end else if (chan_q > 3'h3) begin
                        res_d[chan_q] = sample_in;
                    end
                end
                BUF_ABCD: begin
                    if (chan_q == 3'h0) begin
                        res_d[3] = res_q[2];
                        res_d[2] = res_q[1];
                        res_d[1] = res_q[0];
                        res_d[0] = sample_in;
                    end else if (chan_q > 3'h3) begin
                        res_d[chan_q] = sample_in;
                    end
                end
                default: res_d[chan_q] = sample_in;
            endcase
        end
        if (standby_in) begin
            for (int i = 0; i < 8; i++) begin
                res_d[i] = 10'h000;
            end
        end
    end

    // Read data, word or high byte form
    always_comb begin
        rdata_d = 16'h0000;
        if (rd_in) begin
            if (addr_in == ADDR_CSR) begin
                rdata_d = {8'h00, csr_q};
            end else if (addr_in == ADDR_CR) begin
                rdata_d = {8'h00, cr_q};
            end else if (addr_in[4:3] == ADDR_RES0[4:3]) begin
                rdata_d = {6'h00, res_q[addr_in[2:0]]} & RES_MASK;
            end else if (addr_in[4:3] == ADDR_RESB0[4:3]) begin
                rdata_d = {8'h00, res_q[addr_in[2:0]][9:2]};
            end
        end
    end

    // State registers; manual reset is not wired to any of them
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            csr_q    <= CSR_RESET;
            cr_q     <= CR_RESET;
            armed_q  <= 1'b0;
            state_q  <= ADCSC_IDLE;
            chan_q   <= 3'h0;
            bufcnt_q <= 2'h0;
            rdata_q  <= 16'h0000;
            ext_q    <= 1'b0;
            for (int i = 0; i < 8; i++) begin
                res_q[i] <= 10'h000;
            end
        end else begin
            csr_q    <= csr_d;
            cr_q     <= cr_d;
            armed_q  <= armed_d;
            state_q  <= state_d;
            chan_q   <= chan_d;
            bufcnt_q <= bufcnt_d;
            rdata_q  <= rdata_d;
            ext_q    <= ext_trigger_pin_in;
            for (int i = 0; i < 8; i++) begin
                res_q[i] <= res_d[i];
            end
        end
    end

    assign rdata_out       = rdata_q;
    assign mux_chan_out    = chan_q;
    assign sampling_out    = (state_q == ADCSC_CONV);
    assign high_speed_out  = cr_q[BIT_PWR];
    assign dual_sample_out = cr_q[BIT_DUAL_SAMPLE_ENABLE];
    assign conv_end_irq_out = csr_q[BIT_FLAG] & csr_q[BIT_IE];
endmodule
`default_nettype wire

// *** testbench/adcsc_top_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of the sequencer control block
module adcsc_top_sva
    import adcsc_pkg::*;
(
    input wire logic        sys_clk_in,
    input wire logic        arst_n_in,
    input wire logic        standby_in,
    input wire logic [4:0]  addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic        wr_in,
    input wire logic        rd_in,
    input wire logic [15:0] rdata_out,
    input wire logic        timer_trig_in,
    input wire logic        ext_trigger_pin_in,
    input wire logic        xfer_ack_in,
    input wire logic        sampling_out,
    input wire logic        high_speed_out,
    input wire logic        dual_sample_out,
    input wire logic        conv_end_irq_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!arst_n_in);
    // Read data only stands in the cycle after a read strobe
    a_rdata_idle_zero: assert property (!$past(rd_in) |-> rdata_out == 16'h0000)
        else $error("read data not zero outside a read answer");
    a_cr_top_zero: assert property (rd_in && addr_in == ADDR_CR |=> !rdata_out[7])
        else $error("control register bit 7 read as one");
    a_word_upper_zero: assert property (rd_in && addr_in < 5'h08
        |=> rdata_out[15:10] == 6'h00)
        else $error("result word upper bits not zero");
    a_byte_upper_zero: assert property (rd_in && addr_in[4:3] == 2'b01
        |=> rdata_out[15:8] == 8'h00)
        else $error("byte read upper half not zero");
    // Standby forces sampling, interrupt and high-speed outputs back to the idle picture
    a_standby_clears: assert property (standby_in
        |=> !sampling_out && !conv_end_irq_out && !high_speed_out)
        else $error("standby left the block active");
    a_start_runs: assert property (wr_in && addr_in == ADDR_CSR && wdata_in[BIT_START]
        && !standby_in |-> ##[1:2] sampling_out)
        else $error("start write did not begin conversion");
    a_stop_halts: assert property (wr_in && addr_in == ADDR_CSR && !wdata_in[BIT_START]
        && !timer_trig_in && !ext_trigger_pin_in |-> ##2 !sampling_out)
        else $error("conversion kept running after start cleared");
    // Sampling, once risen, stays high for at least 8 cycles
    a_conv_min_time: assert property ($rose(sampling_out) |-> sampling_out [*8])
        else $error("conversion shorter than minimum");
    a_ack_clears: assert property (xfer_ack_in && !sampling_out |=> !conv_end_irq_out)
        else $error("transfer acknowledge left interrupt raised");
    a_mode_copies: assert property (wr_in && addr_in == ADDR_CR && !standby_in
        |-> ##2 high_speed_out == $past(wdata_in[BIT_PWR], 2)
        && dual_sample_out == $past(wdata_in[BIT_DUAL_SAMPLE_ENABLE], 2))
        else $error("mode outputs do not follow control register");
endmodule
bind adcsc_top adcsc_top_sva u_sva (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
    .standby_in(standby_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .timer_trig_in(timer_trig_in), .ext_trigger_pin_in(ext_trigger_pin_in),
    .xfer_ack_in(xfer_ack_in), .sampling_out(sampling_out), .high_speed_out(high_speed_out),
    .dual_sample_out(dual_sample_out), .conv_end_irq_out(conv_end_irq_out));
`default_nettype wire

// *** testbench/adcsc_far_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Analog source and transfer controller seen from the converter
module adcsc_far_model (
    input  wire logic       sys_clk_in,
    input  wire logic       arst_n_in,
    input  wire logic [2:0] mux_chan_in,
    input  wire logic       sampling_in,
    input  wire logic       irq_in,
    input  wire logic       ack_req_in,
    input  wire logic [6:0] salt_in,
    output logic [9:0]      sample_out,
    output logic            xfer_ack_out
);
    logic [9:0] level;
    // Value names its channel; inverted outside sampling so stale data never matches
    assign level = {mux_chan_in, salt_in ^ {4'h0, mux_chan_in}};
    assign sample_out = sampling_in ? level : ~level;
    // One acknowledge pulse answers a raised end interrupt when asked to
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in)
            xfer_ack_out <= 1'b0;
        else
            xfer_ack_out <= ack_req_in && irq_in && !xfer_ack_out;
    end
endmodule
`default_nettype wire

// *** testbench/adc_sequencer_control_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module adc_sequencer_control_test;
    import adcsc_pkg::*;
    logic        clk = 1'b0, rst_n = 1'b0, standby = 1'b0, manual_rst = 1'b0;
    logic        wr = 1'b0, rd = 1'b0, tmr = 1'b0, ext = 1'b0, ack_req = 1'b0, rd_seen = 1'b0;
    logic        ack, sampling, hs, dual, irq;
    logic [4:0]  addr = 5'h00;
    logic [15:0] wdata = 16'h0000, rdata, r;
    logic [6:0]  salt = 7'h00;
    logic [9:0]  sample;
    logic [2:0]  chan;
    logic [15:0] exp_q[$];
    int          fail_count = 0, num_checks = 0, n;
    always #2.5 clk = ~clk;
    adcsc_top uut (.sys_clk_in(clk), .arst_n_in(rst_n), .standby_in(standby),
        .manual_rst_in(manual_rst), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
        .rdata_out(rdata), .timer_trig_in(tmr), .ext_trigger_pin_in(ext), .xfer_ack_in(ack),
        .sample_in(sample), .mux_chan_out(chan), .sampling_out(sampling), .high_speed_out(hs),
        .dual_sample_out(dual), .conv_end_irq_out(irq));
    adcsc_far_model u_far (.sys_clk_in(clk), .arst_n_in(rst_n), .mux_chan_in(chan),
        .sampling_in(sampling), .irq_in(irq), .ack_req_in(ack_req), .salt_in(salt),
        .sample_out(sample), .xfer_ack_out(ack));
    function automatic logic [15:0] res(input int c);
        return {6'h00, 3'(c), salt ^ 7'(c)};
    endfunction
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One bus cycle; a read leaves its expected answer in the queue
    task automatic bus(input bit w, input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        if (!w) exp_q.push_back(d);
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    // Bounded wait on interrupt or sampling level; n ends as the cycles waited
    task automatic wait_for(input bit on_irq, input logic lvl);
        n = 0;
        while (((on_irq ? irq : sampling) !== lvl) && n < 1000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 1000) check("wait", 16'h0000, 16'h0001);
    endtask
    task automatic close_out;
        $display("Checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Each read answer is matched against the oldest note
    always @(posedge clk) begin
        if (rd_seen) check("rdata", rdata, exp_q.pop_front());
        rd_seen <= rd;
    end
    // Hang guard at 20000 cycles, far beyond the under one thousand cycles the tests need
    initial begin
        #100us;
        fail_count++;
        close_out();
    end
    initial begin
        n = $urandom(32'h0000_efa1);
        salt = 7'($urandom);
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        bus(0, ADDR_CSR, 16'h0000);
        bus(0, ADDR_CR, 16'h0000);
        bus(0, 5'h1f, 16'h0000);
        // Group-single over channels 0..2, interrupt enabled
        bus(1, ADDR_CSR, 16'h006a);
        wait_for(1, 1'b1);
        bus(0, ADDR_CSR, 16'h00ca);
        for (int c = 0; c < 4; c++) begin
            bus(0, ADDR_RES0 + 5'(c), c < 3 ? res(c) : 16'h0000);
            bus(0, ADDR_RESB0 + 5'(c), c < 3 ? res(c) >> 2 : 16'h0000);
        end
        bus(1, ADDR_CSR, 16'h00ca);
        bus(0, ADDR_CSR, 16'h00ca);
        bus(1, ADDR_CSR, 16'h004a);
        bus(0, ADDR_CSR, 16'h004a);
        check("irq", irq, 16'h0000);
        // Timer start, select channel 5; clear without a prior read must fail
        salt <= 7'($urandom);
        bus(1, ADDR_CR, 16'h0010);
        bus(1, ADDR_CSR, 16'h0045);
        repeat (20) @(posedge clk);
        check("idle", sampling, 16'h0000);
        tmr <= 1'b1;
        @(posedge clk);
        tmr <= 1'b0;
        wait_for(1, 1'b1);
        bus(1, ADDR_CSR, 16'h0045);
        bus(0, ADDR_CSR, 16'h00c5);
        ack_req <= 1'b1;
        wait_for(1, 1'b0);
        ack_req <= 1'b0;
        bus(0, ADDR_CSR, 16'h0045);
        bus(0, ADDR_RES0 + 5'd5, res(5));
        // External pin start, channel 7, interrupt masked, short conversion
        bus(1, ADDR_CR, 16'h0030);
        bus(1, ADDR_CSR, 16'h0007);
        ext <= 1'b1;
        wait_for(0, 1'b1);
        wait_for(0, 1'b0);
        check("conv_len", 16'(n), 16'(STATES_FAST));
        repeat (3) @(posedge clk);
        check("irq_masked", irq, 16'h0000);
        ext <= 1'b0;
        bus(0, ADDR_CSR, 16'h0087);
        bus(0, ADDR_RES0 + 5'd7, res(7));
        // Scan with interrupt: halts on the flag, resumes once cleared
        bus(1, ADDR_CR, 16'h0008);
        bus(1, ADDR_CSR, 16'h0070);
        wait_for(0, 1'b1);
        wait_for(0, 1'b0);
        check("conv_len", 16'(n), 16'(STATES_SLOW));
        repeat (5) @(posedge clk);
        check("halted", sampling, 16'h0000);
        bus(0, ADDR_CSR, 16'h00f0);
        bus(1, ADDR_CSR, 16'h0070);
        wait_for(0, 1'b1);
        wait_for(1, 1'b1);
        bus(0, ADDR_CSR, 16'h00f0);
        bus(1, ADDR_CSR, 16'h0000);
        repeat (100) @(posedge clk);
        check("stopped", sampling, 16'h0000);
        bus(0, ADDR_CSR, 16'h0000);
        // Buffered single mode: each start runs one round, flag after the second
        bus(1, ADDR_CR, 16'h0001);
        bus(1, ADDR_CSR, 16'h0020);
        wait_for(0, 1'b1);
        wait_for(0, 1'b0);
        bus(0, ADDR_CSR, 16'h0000);
        r = res(0);
        salt <= ~salt;
        bus(1, ADDR_CSR, 16'h0020);
        wait_for(0, 1'b1);
        wait_for(0, 1'b0);
        bus(0, ADDR_CSR, 16'h0080);
        bus(0, ADDR_RES0, res(0));
        bus(0, ADDR_RES0 + 5'd1, r);
        // Random mode bits; manual reset keeps them, standby clears
        r = 16'($urandom) & 16'h0044;
        bus(1, ADDR_CR, r);
        bus(0, ADDR_CR, r & 16'h007f);
        check("high_speed", hs, 16'(r[6]));
        check("dual", dual, 16'(r[2]));
        bus(1, ADDR_CSR, 16'h0053);
        manual_rst <= 1'b1;
        @(posedge clk);
        manual_rst <= 1'b0;
        bus(0, ADDR_CR, r & 16'h007f);
        bus(0, ADDR_CSR, 16'h0053);
        standby <= 1'b1;
        @(posedge clk);
        standby <= 1'b0;
        bus(0, ADDR_CR, 16'h0000);
        bus(0, ADDR_CSR, 16'h0000);
        bus(0, ADDR_RES0 + 5'd7, 16'h0000);
        repeat (4) @(posedge clk);
        close_out();
    end
endmodule
`default_nettype wire
